// *** hw/bsc_pkg.sv ***
// Constants, bus carriers and state layout for the buck supervisor block.
package bsc_pkg;
  localparam int NBUCK = 5;
  localparam int NLDO = 5;
  localparam int NRAIL = NBUCK + NLDO;
  localparam int NDVS = 3;
  localparam int VW = 7;
  localparam int AW = 8;
  // Clock and timing figures as printed, cycle counts derived from them.
  localparam int CLK_NS = 40;
  localparam int QUAL_NS = 155000;
  localparam int QUAL_CYC = (QUAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_NS = 2000000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOPE_UV_PER_US = 2500;
  localparam int STEP_UV = 10000;
  localparam int STEP_NS = STEP_UV * 1000 / SLOPE_UV_PER_US;
  localparam int STEP_CYC = STEP_NS / CLK_NS;
  localparam int FB_KHZ = 2200;
  localparam int SAT_LO_KHZ = 1700;
  localparam int SAT_HI_KHZ = 2700;
  localparam logic [5:0] PER_FB = 6'(1000000 / (FB_KHZ * CLK_NS));
  localparam logic [5:0] PER_LO = 6'(1000000 / (SAT_LO_KHZ * CLK_NS));
  localparam logic [5:0] PER_HI = 6'(1000000 / (SAT_HI_KHZ * CLK_NS));
  localparam logic [5:0] NOCLK_CYC = 6'(2 * PER_LO);
  localparam logic [2:0] ADC_CUR_CH = 3'h4;
  // Register byte offsets.
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_BSHORT = 8'h04;
  localparam logic [AW-1:0] OFS_LSHORT = 8'h08;
  localparam logic [AW-1:0] OFS_MASKA = 8'h0C;
  localparam logic [AW-1:0] OFS_MASKB = 8'h10;
  localparam logic [AW-1:0] OFS_DVS = 8'h14;
  localparam logic [AW-1:0] OFS_STAT = 8'h18;
  localparam logic [AW-1:0] OFS_PRIM = 8'h20;
  localparam logic [AW-1:0] OFS_ALT = 8'h40;
  localparam logic [AW-1:0] REG_STRIDE = 8'h04;
  // Field positions.
  localparam int CTRL_ECO = 0;
  localparam int CTRL_INCL = 5;
  localparam int CTRL_IRQM = 6;
  localparam int CTRL_MON = 8;
  localparam int DVS_PINEN = 0;
  localparam int DVS_ASG = 3;
  localparam int DVS_CMD = 9;
  localparam int ST_PG = 0;
  localparam int ST_SUM = 1;
  localparam int ST_CLK = 2;
  localparam int ST_SHED = 3;
  localparam int ST_PER = 8;
  // Synchroniser vector positions.
  localparam int AS_SYNC = 0;
  localparam int AS_PIN = 1;
  localparam int AS_SHORT = 4;
  localparam int AS_VWIN = 14;
  localparam int AS_LIGHT = 19;
  localparam int AS_W = 20;
  // Reset values and bus response codes.
  localparam logic [NBUCK-1:0] MASKA_RST = 5'h1E;
  localparam logic [1:0] MASKB_RST = 2'h0;
  localparam logic [VW-1:0] VCODE_RST = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    BSC_PIN_NONE,
    BSC_PIN_SLEEP,
    BSC_PIN_ENA,
    BSC_PIN_ENB
  } bsc_pin_e;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } bsc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bsc_axi_rsp_s;

  typedef struct packed {
    logic [AS_W-1:0] as1;
    logic [AS_W-1:0] as2;
    logic sync_prev;
    logic [5:0] per_cnt;
    logic [5:0] per;
    logic [5:0] ph;
    logic [5:0] rc;
    logic clk_ok;
    logic [NBUCK-1:0] sw_clk;
    logic [NBUCK-1:0] eco;
    logic incl;
    logic irqm;
    logic [2:0] mon_sel;
    logic [NBUCK-1:0] mask_a;
    logic [1:0] mask_b;
    logic [NDVS-1:0] pin_en;
    logic [NDVS-1:0][1:0] pin_asg;
    logic [NDVS-1:0] cmd;
    logic [NBUCK-1:0][VW-1:0] prim;
    logic [NDVS-1:0][VW-1:0] alt;
    logic [NBUCK-1:0] bflag;
    logic [NLDO-1:0] lflag;
    logic [NRAIL-1:0][11:0] qcnt;
    logic [16:0] su_cnt;
    logic su_mask;
    logic [NRAIL-1:0] act_prev;
    logic [NBUCK-1:0][VW-1:0] cur;
    logic [NDVS-1:0][6:0] stp;
    logic irq;
    logic pg;
    logic [NBUCK-1:0] buck_off;
    logic [NLDO-1:0] ldo_off;
    logic [2:0] cm_sel;
    logic [2:0] cm_ch;
    logic shed;
    bsc_axi_rsp_s rsp;
    logic aw_got;
    logic w_got;
    logic [AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } bsc_state_s;
endpackage

// *** hw/bsc_top.sv ***
// Buck supervisor: switching clocks, short handling, power good and DVS.
`timescale 1ns/1ps
module bsc_top #(
  parameter int STARTUP_CYCLES = bsc_pkg::STARTUP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire bsc_pkg::bsc_axi_req_s axi_req_i,
  output bsc_pkg::bsc_axi_rsp_s axi_rsp_o,
  input wire logic switching_sync_in_i,
  input wire logic sleep_request_pin_i,
  input wire logic enable_pin_a_i,
  input wire logic enable_pin_b_i,
  input wire logic [bsc_pkg::NBUCK-1:0] buck_short_i,
  input wire logic [bsc_pkg::NLDO-1:0] linear_short_i,
  input wire logic [bsc_pkg::NBUCK-1:0] vwin_ok_i,
  input wire logic light_load_i,
  input wire logic [bsc_pkg::NRAIL-1:0] rail_active_i,
  input wire logic dev_enable_i,
  input wire logic dual_phase_i,
  input wire logic adc_cur_ok_i,
  output logic [bsc_pkg::NBUCK-1:0] sw_clk_o,
  output logic short_irq_o,
  output logic rails_ok_o,
  output logic [bsc_pkg::NBUCK-1:0] buck_off_o,
  output logic [bsc_pkg::NLDO-1:0] linear_off_o,
  output logic [bsc_pkg::NBUCK-1:0][bsc_pkg::VW-1:0] rail_code_o,
  output logic [2:0] cur_meas_sel_o,
  output logic [2:0] cur_meas_ch_o,
  output logic phase_shed_o
);
  localparam logic [16:0] SU_LAST = 17'(STARTUP_CYCLES - 1);
  localparam logic [11:0] QUAL_LAST = 12'(bsc_pkg::QUAL_CYC - 1);
  localparam logic [6:0] STEP_LAST = 7'(bsc_pkg::STEP_CYC - 1);

  bsc_pkg::bsc_state_s s_r;
  bsc_pkg::bsc_state_s s_nxt;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Returns the register image at an address; bit 32 flags a hit.
  function automatic logic [32:0] rd_reg(input bsc_pkg::bsc_state_s s,
                                         input logic [bsc_pkg::AW-1:0] a);
    logic [32:0] r;
    r = '0;
    r[32] = 1'b1;
    case (a)
      bsc_pkg::OFS_CTRL: begin
        r[bsc_pkg::CTRL_ECO +: bsc_pkg::NBUCK] = s.eco;
        r[bsc_pkg::CTRL_INCL] = s.incl;
        r[bsc_pkg::CTRL_IRQM] = s.irqm;
        r[bsc_pkg::CTRL_MON +: 3] = s.mon_sel;
      end
      bsc_pkg::OFS_BSHORT: r[bsc_pkg::NBUCK-1:0] = s.bflag;
      bsc_pkg::OFS_LSHORT: r[bsc_pkg::NLDO-1:0] = s.lflag;
      bsc_pkg::OFS_MASKA: r[bsc_pkg::NBUCK-1:0] = s.mask_a;
      bsc_pkg::OFS_MASKB: r[1:0] = s.mask_b;
      bsc_pkg::OFS_DVS: begin
        r[bsc_pkg::DVS_PINEN +: bsc_pkg::NDVS] = s.pin_en;
        r[bsc_pkg::DVS_ASG +: 2*bsc_pkg::NDVS] = s.pin_asg;
        r[bsc_pkg::DVS_CMD +: bsc_pkg::NDVS] = s.cmd;
      end
      bsc_pkg::OFS_STAT: begin
        r[bsc_pkg::ST_PG] = s.pg;
        r[bsc_pkg::ST_SUM] = s.su_mask;
        r[bsc_pkg::ST_CLK] = s.clk_ok;
        r[bsc_pkg::ST_SHED] = s.shed;
        r[bsc_pkg::ST_PER +: 6] = s.per;
      end
      default: begin
        r[32] = 1'b0;
        for (int i = 0; i < bsc_pkg::NBUCK; i++) begin
          if (a == bsc_pkg::OFS_PRIM + 8'(i) * bsc_pkg::REG_STRIDE) begin
            r[bsc_pkg::VW-1:0] = s.prim[i];
            r[32] = 1'b1;
          end
        end
        for (int i = 0; i < bsc_pkg::NDVS; i++) begin
          if (a == bsc_pkg::OFS_ALT + 8'(i) * bsc_pkg::REG_STRIDE) begin
            r[bsc_pkg::VW-1:0] = s.alt[i];
            r[32] = 1'b1;
          end
        end
      end
    endcase
    return r;
  endfunction

  always_comb begin
    logic edge_seen;
    logic [5:0] off;
    logic [6:0] p;
    logic [bsc_pkg::NRAIL-1:0] sh;
    logic [bsc_pkg::NRAIL-1:0] set_v;
    logic ar_hs;
    logic clr_b;
    logic clr_l;
    logic sel_alt;
    logic lvl;
    logic [bsc_pkg::VW-1:0] tgt;
    logic [bsc_pkg::NBUCK-1:0] vzero;
    logic [bsc_pkg::NBUCK-1:0] ramping;
    logic [bsc_pkg::NBUCK-1:0] good;
    logic [32:0] rd;
    logic [31:0] wv;
    logic [2:0] ms;
    edge_seen = 1'b0;
    off = '0;
    p = '0;
    sh = '0;
    set_v = '0;
    ar_hs = 1'b0;
    clr_b = 1'b0;
    clr_l = 1'b0;
    sel_alt = 1'b0;
    lvl = 1'b0;
    tgt = '0;
    vzero = '0;
    ramping = '0;
    good = '0;
    rd = '0;
    wv = '0;
    ms = '0;
    s_nxt = s_r;
    // Pins and analog comparator levels pass two flip-flops first.
    s_nxt.as1 = {light_load_i, vwin_ok_i, linear_short_i, buck_short_i,
                 enable_pin_b_i, enable_pin_a_i, sleep_request_pin_i,
                 switching_sync_in_i};
    s_nxt.as2 = s_r.as1;
    s_nxt.sync_prev = s_r.as2[bsc_pkg::AS_SYNC];
    // Period measurement of the sync input, clamped to the lock range.
    edge_seen = s_r.as2[bsc_pkg::AS_SYNC] & ~s_r.sync_prev;
    if (edge_seen) begin
      s_nxt.per_cnt = 6'h01;
      s_nxt.clk_ok = s_r.per_cnt < bsc_pkg::NOCLK_CYC;
      if (s_r.per_cnt >= bsc_pkg::NOCLK_CYC) begin
        s_nxt.per = bsc_pkg::PER_FB;
      end else if (s_r.per_cnt < bsc_pkg::PER_HI) begin
        s_nxt.per = bsc_pkg::PER_HI;
      end else if (s_r.per_cnt > bsc_pkg::PER_LO) begin
        s_nxt.per = bsc_pkg::PER_LO;
      end else begin
        s_nxt.per = s_r.per_cnt;
      end
    end else if (s_r.per_cnt >= bsc_pkg::NOCLK_CYC) begin
      s_nxt.clk_ok = 1'b0;
      s_nxt.per = bsc_pkg::PER_FB;
    end else begin
      s_nxt.per_cnt = s_r.per_cnt + 6'h01;
    end
    s_nxt.ph = (s_r.ph >= s_r.per - 6'h01) ? '0 : s_r.ph + 6'h01;
    s_nxt.rc = (s_r.rc >= bsc_pkg::PER_FB - 6'h01) ? '0 : s_r.rc + 6'h01;
    s_nxt.shed = dual_phase_i & s_r.as2[bsc_pkg::AS_LIGHT];
    for (int i = 0; i < bsc_pkg::NBUCK; i++) begin
      // Rail 1 sits in antiphase to rail 0 when the pair is combined.
      if (dual_phase_i && i == 1) begin
        off = s_r.per >> 1;
      end else begin
        off = 6'((int'(s_r.per) * i) / bsc_pkg::NBUCK);
      end
      p = 7'(s_r.ph) + 7'(off);
      if (p >= 7'(s_r.per)) begin
        p = p - 7'(s_r.per);
      end
      if (s_r.eco[i]) begin
        s_nxt.sw_clk[i] = s_r.rc < (bsc_pkg::PER_FB >> 1);
      end else begin
        s_nxt.sw_clk[i] = p < 7'(s_r.per >> 1);
      end
      if (i == 1 && s_nxt.shed) begin
        s_nxt.sw_clk[i] = 1'b0;
      end
    end
    // Short qualification per rail, bucks first then linear rails.
    sh = s_r.as2[bsc_pkg::AS_SHORT +: bsc_pkg::NRAIL];
    for (int i = 0; i < bsc_pkg::NRAIL; i++) begin
      if (sh[i] && rail_active_i[i]) begin
        set_v[i] = s_r.qcnt[i] == QUAL_LAST;
        s_nxt.qcnt[i] = set_v[i] ? s_r.qcnt[i] : s_r.qcnt[i] + 12'h001;
      end else begin
        s_nxt.qcnt[i] = '0;
      end
    end
    // Startup mask restarts on any rail becoming active.
    s_nxt.act_prev = rail_active_i;
    if (!dev_enable_i || (|(rail_active_i & ~s_r.act_prev))) begin
      s_nxt.su_cnt = '0;
    end else if (s_r.su_cnt != SU_LAST) begin
      s_nxt.su_cnt = s_r.su_cnt + 17'h00001;
    end
    s_nxt.su_mask = s_nxt.su_cnt != SU_LAST;
    // Register reads; clear-on-read loses to a new short.
    ar_hs = axi_req_i.arvalid & s_r.rsp.arready;
    clr_b = ar_hs && axi_req_i.araddr == bsc_pkg::OFS_BSHORT;
    clr_l = ar_hs && axi_req_i.araddr == bsc_pkg::OFS_LSHORT;
    s_nxt.bflag = set_v[bsc_pkg::NBUCK-1:0] |
                  (s_r.bflag & {bsc_pkg::NBUCK{~clr_b}});
    s_nxt.lflag = set_v[bsc_pkg::NRAIL-1:bsc_pkg::NBUCK] |
                  (s_r.lflag & {bsc_pkg::NLDO{~clr_l}});
    s_nxt.irq = |(s_r.bflag | s_r.lflag) & ~s_r.irqm;
    if (ar_hs) begin
      rd = rd_reg(s_r, axi_req_i.araddr);
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata = rd[31:0];
      s_nxt.rsp.rresp = rd[32] ? bsc_pkg::RESP_OKAY : bsc_pkg::RESP_DECERR;
    end else if (s_r.rsp.rvalid && axi_req_i.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    s_nxt.rsp.arready = ~s_nxt.rsp.rvalid;
    // Voltage target selection and DVS ramp on the capable rails.
    for (int i = 0; i < bsc_pkg::NDVS; i++) begin
      case (bsc_pkg::bsc_pin_e'(s_r.pin_asg[i]))
        bsc_pkg::BSC_PIN_SLEEP: lvl = s_r.as2[bsc_pkg::AS_PIN];
        bsc_pkg::BSC_PIN_ENA: lvl = s_r.as2[bsc_pkg::AS_PIN + 1];
        bsc_pkg::BSC_PIN_ENB: lvl = s_r.as2[bsc_pkg::AS_PIN + 2];
        default: lvl = 1'b1;
      endcase
      if (s_r.pin_en[i] && s_r.pin_asg[i] != bsc_pkg::BSC_PIN_NONE) begin
        sel_alt = ~lvl;
      end else begin
        sel_alt = s_r.cmd[i];
      end
      tgt = sel_alt ? s_r.alt[i] : s_r.prim[i];
      vzero[i] = tgt == '0;
      ramping[i] = s_r.cur[i] != tgt;
      if (!ramping[i] || vzero[i]) begin
        s_nxt.stp[i] = '0;
      end else if (s_r.stp[i] != STEP_LAST) begin
        s_nxt.stp[i] = s_r.stp[i] + 7'h01;
      end else begin
        s_nxt.stp[i] = '0;
        s_nxt.cur[i] = (s_r.cur[i] < tgt) ? s_r.cur[i] + 7'h01
                                          : s_r.cur[i] - 7'h01;
      end
    end
    // Rails without DVS jump straight to the primary code.
    for (int i = bsc_pkg::NDVS; i < bsc_pkg::NBUCK; i++) begin
      s_nxt.cur[i] = s_r.prim[i];
      vzero[i] = s_r.prim[i] == '0;
    end
    s_nxt.buck_off = (s_r.bflag & {bsc_pkg::NBUCK{~s_r.su_mask}}) |
                     vzero;
    s_nxt.ldo_off = s_r.lflag & {bsc_pkg::NLDO{~s_r.su_mask}};
    // Power good aggregation over unmasked sources.
    for (int i = 0; i < bsc_pkg::NBUCK; i++) begin
      good[i] = s_r.mask_a[i] || (dual_phase_i && i == 1) ||
                (~sh[i] && (s_r.mask_b[0] ||
                 s_r.as2[bsc_pkg::AS_VWIN + i] || ramping[i]));
    end
    s_nxt.pg = (&good) & (~s_r.incl | adc_cur_ok_i);
    // Current measurement only makes sense on a PWM rail.
    ms = s_r.mon_sel;
    if (ms != '0 && ms <= 3'(bsc_pkg::NBUCK) && !s_r.eco[ms - 3'h1]) begin
      s_nxt.cm_sel = ms;
      s_nxt.cm_ch = bsc_pkg::ADC_CUR_CH;
    end else begin
      s_nxt.cm_sel = '0;
      s_nxt.cm_ch = '0;
    end
    // Write path: address and data are taken in either order.
    if (axi_req_i.awvalid && s_r.rsp.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && s_r.rsp.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req_i.wdata;
      s_nxt.wstrb = axi_req_i.wstrb;
    end
    if (s_r.rsp.bvalid && axi_req_i.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.rsp.bvalid) begin
      rd = rd_reg(s_r, s_r.awaddr);
      wv = wmerge(rd[31:0], s_r.wdata, s_r.wstrb);
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = rd[32] ? bsc_pkg::RESP_OKAY : bsc_pkg::RESP_DECERR;
      case (s_r.awaddr)
        bsc_pkg::OFS_CTRL: begin
          s_nxt.eco = wv[bsc_pkg::CTRL_ECO +: bsc_pkg::NBUCK];
          s_nxt.incl = wv[bsc_pkg::CTRL_INCL];
          s_nxt.irqm = wv[bsc_pkg::CTRL_IRQM];
          s_nxt.mon_sel = wv[bsc_pkg::CTRL_MON +: 3];
        end
        bsc_pkg::OFS_MASKA: s_nxt.mask_a = wv[bsc_pkg::NBUCK-1:0];
        bsc_pkg::OFS_MASKB: s_nxt.mask_b = wv[1:0];
        bsc_pkg::OFS_DVS: begin
          s_nxt.pin_en = wv[bsc_pkg::DVS_PINEN +: bsc_pkg::NDVS];
          s_nxt.pin_asg = wv[bsc_pkg::DVS_ASG +: 2*bsc_pkg::NDVS];
          s_nxt.cmd = wv[bsc_pkg::DVS_CMD +: bsc_pkg::NDVS];
        end
        default: begin
          for (int i = 0; i < bsc_pkg::NBUCK; i++) begin
            if (s_r.awaddr == bsc_pkg::OFS_PRIM +
                8'(i) * bsc_pkg::REG_STRIDE) begin
              s_nxt.prim[i] = wv[bsc_pkg::VW-1:0];
            end
          end
          for (int i = 0; i < bsc_pkg::NDVS; i++) begin
            if (s_r.awaddr == bsc_pkg::OFS_ALT +
                8'(i) * bsc_pkg::REG_STRIDE) begin
              s_nxt.alt[i] = wv[bsc_pkg::VW-1:0];
            end
          end
        end
      endcase
    end
    s_nxt.rsp.awready = ~s_nxt.aw_got;
    s_nxt.rsp.wready = ~s_nxt.w_got;
    if (srst_i) begin
      s_nxt = '0;
      s_nxt.per = bsc_pkg::PER_FB;
      s_nxt.mask_a = bsc_pkg::MASKA_RST;
      s_nxt.mask_b = bsc_pkg::MASKB_RST;
      s_nxt.prim = {bsc_pkg::NBUCK{bsc_pkg::VCODE_RST}};
      s_nxt.cur = {bsc_pkg::NBUCK{bsc_pkg::VCODE_RST}};
      s_nxt.su_mask = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s_r <= s_nxt;
  end

  assign axi_rsp_o = s_r.rsp;
  assign sw_clk_o = s_r.sw_clk;
  assign short_irq_o = s_r.irq;
  assign rails_ok_o = s_r.pg;
  assign buck_off_o = s_r.buck_off;
  assign linear_off_o = s_r.ldo_off;
  assign rail_code_o = s_r.cur;
  assign cur_meas_sel_o = s_r.cm_sel;
  assign cur_meas_ch_o = s_r.cm_ch;
  assign phase_shed_o = s_r.shed;

  // Checks sit beside the logic; they watch registered state plus the bus request, rail_active_i and dev_enable_i inputs.
  logic ar_hs_w;
  assign ar_hs_w = axi_req_i.arvalid && s_r.rsp.arready &&
                   axi_req_i.araddr == bsc_pkg::OFS_BSHORT;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  fallback_freq_a: assert property (!s_r.clk_ok |->
    s_r.per == bsc_pkg::PER_FB) else $error("Fallback period wrong.");
  clamp_range_a: assert property (s_r.clk_ok |->
    s_r.per >= bsc_pkg::PER_HI && s_r.per <= bsc_pkg::PER_LO)
    else $error("Period outside lock range.");
  irq_gate_a: assert property (##1 short_irq_o ==
    ($past(|(s_r.bflag | s_r.lflag)) && !$past(s_r.irqm)))
    else $error("Short interrupt gating wrong.");
  hold_off_a: assert property (s_r.bflag[0] && !s_r.su_mask |=>
    buck_off_o[0]) else $error("Shorted rail not held off.");
  clear_read_a: assert property (s_r.bflag[0] && ar_hs_w &&
    s_r.qcnt[0] != QUAL_LAST |=> !s_r.bflag[0])
    else $error("Flag not cleared by read.");
  qual_time_a: assert property ($rose(s_r.bflag[0]) |->
    $past(s_r.qcnt[0]) == QUAL_LAST) else $error("Short qualified early.");
  su_restart_a: assert property (dev_enable_i &&
    |(rail_active_i & ~s_r.act_prev) |=> s_r.su_mask && s_r.su_cnt == '0)
    else $error("Startup mask not restarted.");
  all_masked_a: assert property (&s_r.mask_a && !s_r.incl |=>
    rails_ok_o) else $error("Masked sources drop power good.");
  ramp_step_a: assert property ($changed(s_r.cur[0]) |->
    $past(s_r.stp[0]) == STEP_LAST) else $error("Ramp step too fast.");
  mon_pwm_a: assert property (cur_meas_ch_o != '0 |->
    cur_meas_ch_o == bsc_pkg::ADC_CUR_CH && !s_r.eco[cur_meas_sel_o - 3'h1])
    else $error("Current monitor on ECO rail.");

  short_seen_c: cover property ($rose(s_r.bflag[0]));
  sync_lock_c: cover property ($rose(s_r.clk_ok));
  pg_up_c: cover property ($rose(rails_ok_o));
  ramp_done_c: cover property ($fell(s_r.stp[0] != '0));
endmodule

// *** tb/bsc_sync_src.sv ***
// Far-side source of the external switching sync clock.
`timescale 1ns/1ps
module bsc_sync_src (
  input wire logic [5:0] per_i,
  output logic sync_o
);
  // Period is in reference cycles; zero stops the clock low, as an idle
  // source would. The odd start offset keeps it out of phase with the bench.
  initial begin
    sync_o = 1'b0;
    #7;
    forever begin
      if (per_i != 6'h00) begin
        sync_o = 1'b1;
        #(per_i * 20);
        sync_o = 1'b0;
        #(per_i * 20);
      end else begin
        #40;
      end
    end
  end
endmodule

// *** tb/buck_supervisor_control_tb.sv ***
// Self-checking bench for the buck supervisor over its register bus.
`timescale 1ns/1ps
module buck_supervisor_control_tb;
  logic ck, rst, pa, dev, adc, sync, irq, pg, shed;
  logic [5:0] per;
  logic [4:0] bs, ls, vw, sw, boff, loff;
  logic [9:0] act;
  logic [4:0][6:0] code;
  logic [2:0] msel, mch;
  logic [31:0] d;
  logic [1:0] rs;
  logic [5:0] pt [4] = '{6'h0C, 6'h14, 6'h05, 6'h00};
  logic [5:0] ex [4] = '{6'h0C, 6'h0E, 6'h09, 6'h0B};
  int err_total, compares;
  bsc_pkg::bsc_axi_req_s q;
  bsc_pkg::bsc_axi_rsp_s r;

  bsc_sync_src src (.per_i(per), .sync_o(sync));
  bsc_top #(.STARTUP_CYCLES(50)) dut (
    .ref_clk_i(ck), .srst_i(rst), .axi_req_i(q), .axi_rsp_o(r),
    .switching_sync_in_i(sync), .sleep_request_pin_i(1'b0),
    .enable_pin_a_i(pa), .enable_pin_b_i(1'b0), .buck_short_i(bs),
    .linear_short_i(ls), .vwin_ok_i(vw), .light_load_i(1'b0),
    .rail_active_i(act), .dev_enable_i(dev), .dual_phase_i(1'b0),
    .adc_cur_ok_i(adc), .sw_clk_o(sw), .short_irq_o(irq),
    .rails_ok_o(pg), .buck_off_o(boff), .linear_off_o(loff),
    .rail_code_o(code), .cur_meas_sel_o(msel), .cur_meas_ch_o(mch),
    .phase_shed_o(shed));

  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ck);
  endtask

  // Handshakes are judged at the falling edge, where the slave's registered
  // outputs are settled, and acted on at the following rising edge.
  task automatic tick(inout int n);
    @(negedge ck);
    n++;
    if (n > 300) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tb;
    n = 0;
    {q.awvalid, q.awaddr, q.wvalid, q.wdata} <= {1'h1, a, 1'h1, v};
    do begin
      tick(n);
      ta = q.awvalid & r.awready;
      tw = q.wvalid & r.wready;
      tb = r.bvalid;
      @(posedge ck);
      if (ta) q.awvalid <= 1'h0;
      if (tw) q.wvalid <= 1'h0;
    end while (!tb);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    n = 0;
    {q.arvalid, q.araddr} <= {1'h1, a};
    do begin
      tick(n);
      ta = q.arvalid & r.arready;
      tr = r.rvalid;
      {d, rs} = {r.rdata, r.rresp};
      @(posedge ck);
      if (ta) q.arvalid <= 1'h0;
    end while (!tr);
  endtask

  initial begin
    ck = 1'h0;
    forever #20 ck = ~ck;
  end

  initial begin
    {rst, dev, pa, adc} = 4'h9;
    {bs, ls, vw, act, per} = '0;
    q = '0;
    // Response ready is held high throughout, which the bus permits.
    {q.wstrb, q.bready, q.rready} = 6'h3F;
    err_total = 0;
    compares = 0;
    cyc(3);
    rst <= 1'h0;
    {dev, act} <= {1'h1, 10'h3FF};
    cyc(2);
    rd(bsc_pkg::OFS_STAT);
    chk(d[1], 32'h1);
    rd(bsc_pkg::OFS_MASKA);
    chk(d, 32'h1E);
    rd(bsc_pkg::OFS_DVS);
    chk(d, 32'h0);
    rd(8'h3C);
    chk({d, rs}, {32'h0, bsc_pkg::RESP_DECERR});
    cyc(60);
    rd(bsc_pkg::OFS_STAT);
    chk(d[1], 32'h0);
    vw <= 5'h1F;
    cyc(6);
    chk(pg, 32'h1);
    vw <= 5'h1E;
    cyc(6);
    chk(pg, 32'h0);
    vw <= 5'h01;
    cyc(6);
    chk(pg, 32'h1);
    vw <= 5'h00;
    wr(bsc_pkg::OFS_MASKB, 32'h1);
    cyc(6);
    chk(pg, 32'h1);
    wr(bsc_pkg::OFS_CTRL, 32'h20);
    adc <= 1'h0;
    cyc(6);
    chk(pg, 32'h0);
    adc <= 1'h1;
    vw <= 5'h1F;
    wr(bsc_pkg::OFS_MASKB, 32'h0);
    wr(bsc_pkg::OFS_CTRL, 32'h300);
    cyc(3);
    chk({msel, mch}, {3'h3, 3'h4});
    // Rail 2 gets a live code so that only its short can turn it off.
    wr(bsc_pkg::OFS_PRIM + 8'h08, 32'h1);
    cyc(3);
    // Long qualification: just short of the count nothing may happen yet.
    {bs, ls} <= {5'h04, 5'h01};
    cyc(3860);
    chk({irq, boff, loff}, {1'h0, 5'h1B, 5'h00});
    cyc(30);
    chk({irq, boff, loff}, {1'h1, 5'h1F, 5'h01});
    {bs, ls} <= '0;
    wr(bsc_pkg::OFS_CTRL, 32'h40);
    cyc(3);
    chk({irq, boff}, {1'h0, 5'h1F});
    rd(bsc_pkg::OFS_BSHORT);
    chk(d, 32'h4);
    rd(bsc_pkg::OFS_LSHORT);
    chk(d, 32'h1);
    rd(bsc_pkg::OFS_BSHORT);
    chk(d, 32'h0);
    cyc(3);
    chk({boff, loff}, {5'h1B, 5'h00});
    for (int i = 0; i < 4; i++) begin
      per <= pt[i];
      cyc(120);
      rd(bsc_pkg::OFS_STAT);
      chk({d[13:8], d[2]}, {ex[i], pt[i] != 6'h00});
    end
    wr(bsc_pkg::OFS_PRIM, 32'h3);
    cyc(150);
    chk(code[0] < 7'h03, 32'h1);
    cyc(250);
    chk({code[0], boff[0]}, {7'h03, 1'h0});
    wr(bsc_pkg::OFS_ALT, 32'h0);
    wr(bsc_pkg::OFS_DVS, 32'h200);
    cyc(3);
    chk(boff[0], 32'h1);
    wr(bsc_pkg::OFS_DVS, 32'h11);
    pa <= 1'h1;
    cyc(6);
    chk(boff[0], 32'h0);
    pa <= 1'h0;
    cyc(6);
    chk(boff[0], 32'h1);
    final_report();
  end
endmodule
